// ==== eid_extended_decode.sv ====
/*
 * Extended instruction decoder and executor: pointer add/subtract, the
 * add/subtract-and-return forms, call through working register, the two
 * indexed moves and push literal, plus the indexed literal offset flag.
 * Assumes one instruction word per cycle with instrValid, a core that
 * supplies the stack top, the working register and the latch bytes, and
 * that stalls fetch while busy is high.
 */
`timescale 1ns/1ps
module eid_extended_decode
    import eid_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              extendedSetEnableBit,
    input  wire logic              instrValid,
    input  wire logic [15:0]       instrWord,
    input  wire logic [PC_W-1:0]   stackTop,
    input  wire logic [PC_W-1:0]   pcPlusTwo,
    input  wire logic [7:0]        workingRegister,
    input  wire logic [7:0]        pcLatchHigh,
    input  wire logic [4:0]        pcLatchUpper,
    output eid_ptrs_t              ptrs,
    output eid_mem_wr_t            memWrite,
    output eid_move_t              move,
    output logic                   busy,
    output logic                   pcLoad,
    output logic [PC_W-1:0]        pcValue,
    output logic                   stackPush,
    output logic [PC_W-1:0]        stackPushValue,
    output logic                   stackPop,
    output logic                   extDecoded,
    output logic                   indexedOffsetMode,
    output logic                   statusWriteBlock
);
    eid_state_t       state;
    eid_state_t       next_state;
    eid_ptrs_t        next_ptrs;
    eid_mem_wr_t      next_memWrite;
    eid_move_t        next_move;
    logic             next_pcLoad;
    logic [PC_W-1:0]  next_pcValue;
    logic             next_stackPush;
    logic [PC_W-1:0]  next_stackPushValue;
    logic             next_stackPop;
    logic             next_extDecoded;
    logic             enabled;
    logic             next_enabled;
    eid_op_t          op;
    logic [1:0]       sel;
    logic [5:0]       lit6;
    logic [PTR_W-1:0] aluIn;
    logic [PTR_W-1:0] aluOut;
    logic             aluSub;
    logic [PTR_W-1:0] ptr2Dec;
    logic [7:0]       opField;
    logic             twoCycleOp;

    // One adder serves add, subtract and both return forms
    eid_ptr_alu u_alu (
        .ptrIn   (aluIn),
        .literal (lit6),
        .subtract(aluSub),
        .ptrOut  (aluOut)
    );

    // Decode of the first instruction word
    always_comb begin
        opField = instrWord[OPC_HI:OPC_LO];
        sel     = instrWord[SEL_HI:SEL_LO];
        lit6    = instrWord[LIT6_HI:0];
        op      = EID_OP_NONE;
        // Words seen while a two-cycle form finishes are never decoded
        if (enabled && instrValid && state == EID_ST_FETCH) begin
            if (opField == OPC_ADD_PTR) begin
                op = (sel == SEL_PTR_TWO) ? EID_OP_ADD_RET : EID_OP_ADD_PTR;
            end else if (opField == OPC_SUB_PTR) begin
                op = (sel == SEL_PTR_TWO) ? EID_OP_SUB_RET : EID_OP_SUB_PTR;
            end else if (instrWord == WORD_CALL_W) begin
                op = EID_OP_CALL_W;
            end else if (opField == OPC_MOVE_IDX) begin
                op = instrWord[DEST_BIT] ? EID_OP_MOVE_IDX : EID_OP_MOVE_FILE;
            end else if (opField == OPC_PUSH_LIT) begin
                op = EID_OP_PUSH_LIT;
            end
        end
    end

    // Operand selection for the pointer adjust unit
    always_comb begin
        aluSub = (op == EID_OP_SUB_PTR) || (op == EID_OP_SUB_RET);
        unique case (sel)
            2'b00:   aluIn = ptrs.ptr0;
            2'b01:   aluIn = ptrs.ptr1;
            default: aluIn = ptrs.ptr2;
        endcase
        // Push stores first and then steps down, so the old value is the address
        ptr2Dec = ptrs.ptr2 - {{(PTR_W-1){1'b0}}, 1'b1};
    end

    // Next-state and execute
    always_comb begin
        next_state          = state;
        next_ptrs           = ptrs;
        next_memWrite       = '0;
        next_move           = move;
        next_move.valid     = 1'b0;
        next_pcLoad         = 1'b0;
        next_pcValue        = pcValue;
        next_stackPush      = 1'b0;
        next_stackPushValue = stackPushValue;
        next_stackPop       = 1'b0;
        next_extDecoded     = (op != EID_OP_NONE);
        // Enable is registered, so a change lands one clock later, even during a two-cycle form
        next_enabled        = extendedSetEnableBit;
        unique case (state)
            EID_ST_FETCH: begin
                unique case (op)
                    EID_OP_ADD_PTR, EID_OP_SUB_PTR: begin
                        unique case (sel)
                            2'b00:   next_ptrs.ptr0 = aluOut;
                            2'b01:   next_ptrs.ptr1 = aluOut;
                            default: next_ptrs.ptr2 = aluOut;
                        endcase
                    end
                    EID_OP_ADD_RET, EID_OP_SUB_RET: begin
                        // Stack top is taken in the cycle that pointer two is written
                        next_ptrs.ptr2 = aluOut;
                        next_pcLoad    = 1'b1;
                        next_pcValue   = stackTop;
                        next_stackPop  = 1'b1;
                        next_state     = EID_ST_RETNOP;
                    end
                    EID_OP_CALL_W: begin
                        next_stackPush      = 1'b1;
                        next_stackPushValue = pcPlusTwo;
                        next_pcLoad         = 1'b1;
                        next_pcValue        = {pcLatchUpper, pcLatchHigh, workingRegister};
                        next_state          = EID_ST_CALLNOP;
                    end
                    EID_OP_MOVE_FILE, EID_OP_MOVE_IDX: begin
                        next_move.toFile    = (op == EID_OP_MOVE_FILE);
                        next_move.srcOffset = instrWord[OFFS_HI:0];
                        next_state          = EID_ST_MOVE2;
                    end
                    EID_OP_PUSH_LIT: begin
                        next_memWrite.writeEn = 1'b1;
                        next_memWrite.addr    = ptrs.ptr2;
                        next_memWrite.data    = instrWord[7:0];
                        next_ptrs.ptr2        = ptr2Dec;
                    end
                    default: begin
                    end
                endcase
            end
            EID_ST_RETNOP, EID_ST_CALLNOP: begin
                next_state = EID_ST_FETCH;
            end
            EID_ST_MOVE2: begin
                if (instrValid) begin
                    // A second word without the tag drops the move
                    if (instrWord[OPC_HI:FILE_HI+1] == SECOND_TAG) begin
                        next_move.valid     = 1'b1;
                        next_move.dstFile   = instrWord[FILE_HI:0];
                        next_move.dstOffset = instrWord[OFFS_HI:0];
                    end
                    next_state = EID_ST_FETCH;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state          <= EID_ST_FETCH;
            ptrs           <= '{PTR_RESET, PTR_RESET, PTR_RESET};
            memWrite       <= '0;
            move           <= '0;
            pcLoad         <= 1'b0;
            pcValue        <= '0;
            stackPush      <= 1'b0;
            stackPushValue <= '0;
            stackPop       <= 1'b0;
            extDecoded     <= 1'b0;
            enabled        <= 1'b0;
        end else begin
            state          <= next_state;
            ptrs           <= next_ptrs;
            memWrite       <= next_memWrite;
            move           <= next_move;
            pcLoad         <= next_pcLoad;
            pcValue        <= next_pcValue;
            stackPush      <= next_stackPush;
            stackPushValue <= next_stackPushValue;
            stackPop       <= next_stackPop;
            extDecoded     <= next_extDecoded;
            enabled        <= next_enabled;
        end
    end

    // Busy spans the decode cycle of a two-cycle form and the cycle after it; a move holds it until its second word is valid
    always_comb begin
        unique case (op)
            EID_OP_ADD_RET, EID_OP_SUB_RET, EID_OP_CALL_W: twoCycleOp = 1'b1;
            EID_OP_MOVE_FILE, EID_OP_MOVE_IDX:             twoCycleOp = 1'b1;
            default:                                       twoCycleOp = 1'b0;
        endcase
        busy              = (state != EID_ST_FETCH) || twoCycleOp;
        indexedOffsetMode = enabled;
        statusWriteBlock  = extDecoded;
    end
endmodule

// ==== eid_pkg.sv ====
/*
 * Package for the extended instruction decoder: opcode fields, encodings,
 * pointer widths, reset values and the carrier structs.
 * Assumes 16-bit instruction words and 12-bit file select pointers.
 */
package eid_pkg;

    localparam int          PTR_W        = 12;
    localparam int          PC_W         = 21;
    localparam logic [7:0]  OPC_ADD_PTR  = 8'hE8;
    localparam logic [7:0]  OPC_SUB_PTR  = 8'hE9;
    localparam logic [7:0]  OPC_PUSH_LIT = 8'hEA;
    localparam logic [7:0]  OPC_MOVE_IDX = 8'hEB;
    localparam logic [15:0] WORD_CALL_W  = 16'h0014;
    localparam logic [3:0]  SECOND_TAG   = 4'hF;
    localparam logic [1:0]  SEL_PTR_TWO  = 2'h3;
    localparam int          OPC_HI       = 15;
    localparam int          OPC_LO       = 8;
    localparam int          SEL_HI       = 7;
    localparam int          SEL_LO       = 6;
    localparam int          LIT6_HI      = 5;
    localparam int          DEST_BIT     = 7;
    localparam int          OFFS_HI      = 6;
    localparam int          FILE_HI      = 11;
    localparam logic [PTR_W-1:0] PTR_RESET = 12'h000;

    typedef enum logic [3:0] {
        EID_OP_NONE      = 4'b0000,
        EID_OP_ADD_PTR   = 4'b0001,
        EID_OP_SUB_PTR   = 4'b0010,
        EID_OP_ADD_RET   = 4'b0011,
        EID_OP_SUB_RET   = 4'b0100,
        EID_OP_CALL_W    = 4'b0101,
        EID_OP_MOVE_FILE = 4'b0110,
        EID_OP_MOVE_IDX  = 4'b0111,
        EID_OP_PUSH_LIT  = 4'b1000
    } eid_op_t;

    typedef enum logic [1:0] {
        EID_ST_FETCH  = 2'b00,
        EID_ST_RETNOP = 2'b01,
        EID_ST_CALLNOP= 2'b10,
        EID_ST_MOVE2  = 2'b11
    } eid_state_t;

    typedef struct packed {
        logic [PTR_W-1:0] ptr0;
        logic [PTR_W-1:0] ptr1;
        logic [PTR_W-1:0] ptr2;
    } eid_ptrs_t;

    typedef struct packed {
        logic             writeEn;
        logic [PTR_W-1:0] addr;
        logic [7:0]       data;
    } eid_mem_wr_t;

    typedef struct packed {
        logic             valid;
        logic             toFile;
        logic [6:0]       srcOffset;
        logic [6:0]       dstOffset;
        logic [PTR_W-1:0] dstFile;
    } eid_move_t;

endpackage

// ==== eid_prog_mem.sv ====
/* Program memory model: a requested word is valid for one cycle;
   when idle, valid is low and the word lines toggle. */
`timescale 1ns/1ps
module eid_prog_mem (
    input  wire logic   clk,
    output logic        instrValid,
    output logic [15:0] instrWord
);
    logic        req = 1'b0;
    logic [15:0] reqWord = '0;
    initial begin
        instrValid = 1'b0;
        instrWord  = '0;
    end
    always @(negedge clk) begin
        instrValid <= req;
        instrWord  <= req ? reqWord : ~instrWord;
        req        <= 1'b0;
    end
    task automatic fetch(input logic [15:0] w);
        @(posedge clk);
        req     = 1'b1;
        reqWord = w;
    endtask
endmodule

// ==== eid_ptr_alu.sv ====
/*
 * Pointer adjust unit: adds or subtracts an unsigned six-bit literal
 * to the full width of one file select pointer.
 * Assumes the caller selects the pointer and the direction.
 */
`timescale 1ns/1ps
module eid_ptr_alu
    import eid_pkg::*;
(
    input  wire logic [PTR_W-1:0] ptrIn,
    input  wire logic [5:0]       literal,
    input  wire logic             subtract,
    output logic      [PTR_W-1:0] ptrOut
);
    logic [PTR_W-1:0] litWide;

    always_comb begin
        litWide = {{(PTR_W-6){1'b0}}, literal};
        ptrOut  = subtract ? (ptrIn - litWide) : (ptrIn + litWide);
    end
endmodule

// ==== eid_sva.sv ====
/* Port assertions for the extended decoder.
   Bound onto eid_extended_decode from tb_top. */
`timescale 1ns/1ps
module eid_sva
    import eid_pkg::*;
(
    input wire logic            clk,
    input wire logic            rst_b,
    input wire logic            extendedSetEnableBit,
    input wire logic            instrValid,
    input wire logic [15:0]     instrWord,
    input wire logic [PC_W-1:0] stackTop,
    input wire logic [PC_W-1:0] pcPlusTwo,
    input wire logic [7:0]      workingRegister,
    input wire logic [7:0]      pcLatchHigh,
    input wire logic [4:0]      pcLatchUpper,
    input wire eid_ptrs_t       ptrs,
    input wire eid_mem_wr_t     memWrite,
    input wire eid_move_t       move,
    input wire logic            busy,
    input wire logic            pcLoad,
    input wire logic [PC_W-1:0] pcValue,
    input wire logic            stackPush,
    input wire logic [PC_W-1:0] stackPushValue,
    input wire logic            stackPop,
    input wire logic            extDecoded,
    input wire logic            indexedOffsetMode,
    input wire logic            statusWriteBlock
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_go(logic [7:0] o, logic c);
        indexedOffsetMode && instrValid && !$past(busy) && instrWord[15:8] == o && c;
    endsequence
    sequence s_ret;
        pcLoad && stackPop && busy && pcValue == $past(stackTop)
        && ptrs.ptr2 == $past(ptrs.ptr2) + PTR_W'($past(instrWord[5:0])) ##1 !pcLoad && !stackPop;
    endsequence
    a_mode_follows: assert property ($past(rst_b)
        |-> indexedOffsetMode == $past(extendedSetEnableBit)) else $error("mode flag");
    a_off_quiet: assert property (!indexedOffsetMode
        |=> !extDecoded && !pcLoad && !memWrite.writeEn) else $error("decoded while off");
    a_add_ptr0: assert property (s_go(OPC_ADD_PTR, instrWord[7:6] == 2'h0)
        |=> extDecoded && ptrs.ptr0 == $past(ptrs.ptr0) + PTR_W'($past(instrWord[5:0])))
        else $error("add pointer");
    a_sub_ptr1: assert property (s_go(OPC_SUB_PTR, instrWord[7:6] == 2'h1)
        |=> !pcLoad && ptrs.ptr1 == $past(ptrs.ptr1) - PTR_W'($past(instrWord[5:0])))
        else $error("sub pointer");
    a_ret_form: assert property (s_go(OPC_ADD_PTR, instrWord[7:6] == SEL_PTR_TWO)
        |=> s_ret) else $error("add and return");
    a_call_seq: assert property (s_go(8'h00, instrWord == WORD_CALL_W)
        |=> stackPush && pcLoad && stackPushValue == $past(pcPlusTwo) && pcValue ==
        {$past(pcLatchUpper), $past(pcLatchHigh), $past(workingRegister)} ##1 !stackPush)
        else $error("call");
    a_push_write: assert property (s_go(OPC_PUSH_LIT, 1'b1)
        |=> memWrite.writeEn && memWrite.addr == $past(ptrs.ptr2) && memWrite.data ==
        $past(instrWord[7:0]) && ptrs.ptr2 == $past(ptrs.ptr2) - 12'h001) else $error("push");
    a_flags_kept: assert property (indexedOffsetMode && instrValid && !$past(busy)
        && (instrWord[15:10] == 6'h3A || instrWord == WORD_CALL_W) |=> statusWriteBlock)
        else $error("status block");
    a_move_pair: assert property (s_go(OPC_MOVE_IDX, 1'b1) ##1 instrWord[15:12] == SECOND_TAG
        && instrValid |=> move.valid && move.toFile == !$past(instrWord[DEST_BIT], 2)
        && move.srcOffset == $past(instrWord[6:0], 2)) else $error("move pair");
endmodule

// ==== tb_top.sv ====
/* Self-checking bench for the extended decoder.
   Assumes eid_pkg, the decoder, eid_prog_mem and eid_sva compiled first. */
`timescale 1ns/1ps
module tb_top import eid_pkg::*;;
    typedef struct packed {
        eid_ptrs_t p; logic w; logic [PTR_W-1:0] a; logic [7:0] d;
        logic pl; logic [PC_W-1:0] pv; logic ps; logic [PC_W-1:0] sv; logic pp;
    } eid_note_t;
    logic clk = 1'b0, rst_b = 1'b0, extendedSetEnableBit = 1'b0, instrValid;
    logic [15:0] instrWord;
    logic [PC_W-1:0] stackTop = '0, pcPlusTwo = '0, pcValue, stackPushValue, pv = '0, sv = '0;
    logic [7:0] workingRegister = '0, pcLatchHigh = '0;
    logic [4:0] pcLatchUpper = '0;
    eid_ptrs_t ptrs, prev = '0;
    eid_mem_wr_t memWrite;
    eid_move_t move;
    logic busy, pcLoad, stackPush, stackPop, extDecoded, indexedOffsetMode, statusWriteBlock;
    logic [PTR_W-1:0] ep [3] = '{default: '0};
    eid_note_t notes [$];
    eid_move_t moves [$];
    int seed = 32'h230f_cf94, errors = 0, checkCount = 0;
    always #12.5 clk = ~clk;
    eid_extended_decode DUT (
        .clk(clk), .rst_b(rst_b), .extendedSetEnableBit(extendedSetEnableBit),
        .instrValid(instrValid), .instrWord(instrWord), .stackTop(stackTop),
        .pcPlusTwo(pcPlusTwo), .workingRegister(workingRegister), .pcLatchHigh(pcLatchHigh),
        .pcLatchUpper(pcLatchUpper), .ptrs(ptrs), .memWrite(memWrite), .move(move),
        .busy(busy), .pcLoad(pcLoad), .pcValue(pcValue), .stackPush(stackPush),
        .stackPushValue(stackPushValue), .stackPop(stackPop), .extDecoded(extDecoded),
        .indexedOffsetMode(indexedOffsetMode), .statusWriteBlock(statusWriteBlock)
    );
    eid_prog_mem mem (.clk, .instrValid, .instrWord);
    task automatic report(input bit bad, input string s);
        checkCount++;
        if (bad) begin
            errors++;
            $display("[ERR] %0t %s", $time, s);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmpN(input eid_note_t e, input eid_note_t g);
        if (g.w !== 1'b1) begin
            g.a = '0;
            g.d = '0;
        end
        report(e !== g, "pointer or flow result");
    endtask
    task automatic cmpM(input eid_move_t e, input eid_move_t g);
        report(e[27:12] !== g[27:12] || (e.toFile ? e.dstFile !== g.dstFile
            : e.dstOffset !== g.dstOffset), "move fields");
    endtask
    // Issues a word; operands and the expected outcome are set in its cycle
    task automatic op(input logic [15:0] w, input bit note);
        eid_note_t n;
        int x;
        mem.fetch(w);
        @(negedge clk);
        {stackTop, pcPlusTwo} = 42'({$random(seed), $random(seed)});
        {pcLatchUpper, pcLatchHigh, workingRegister} = 21'($random(seed));
        x = (w[7:6] == SEL_PTR_TWO) ? 2 : int'(w[7:6]);
        n = '0;
        // Words the decoder must ignore or that are moves leave the model untouched
        if (note) begin
            if (w[15:9] == 7'h74) begin
                ep[x] = w[8] ? ep[x] - PTR_W'(w[5:0]) : ep[x] + PTR_W'(w[5:0]);
                n.pl = (w[7:6] == SEL_PTR_TWO);
                n.pp = n.pl;
                if (n.pl) pv = stackTop;
            end else if (w[15:8] == OPC_PUSH_LIT) begin
                n.w = 1'b1;
                n.a = ep[2];
                n.d = w[7:0];
                ep[2] = ep[2] - 12'h001;
            end else begin
                {n.pl, n.ps} = 2'h3;
                pv = {pcLatchUpper, pcLatchHigh, workingRegister};
                sv = pcPlusTwo;
            end
            n.p = {ep[0], ep[1], ep[2]};
            n.pv = pv;
            n.sv = sv;
            notes.push_back(n);
        end
    endtask
    task automatic mv(input logic [15:0] a, input logic [15:0] b);
        if (b[15:12] == SECOND_TAG) moves.push_back({1'b1, !a[7], a[6:0], b[6:0], b[11:0]});
        op(a, 0);
        op(b, 0);
        @(posedge clk);
    endtask
    always @(negedge clk) begin
        if (rst_b && (ptrs !== prev || (memWrite.writeEn | pcLoad | stackPush) === 1'b1)) begin
            if (notes.size() == 0) report(1'b1, "unexpected result");
            else cmpN(notes.pop_front(), {ptrs, memWrite, pcLoad, pcValue, stackPush, stackPushValue, stackPop});
        end
        if (rst_b && move.valid === 1'b1) begin
            if (moves.size() == 0) report(1'b1, "unexpected move");
            else cmpM(moves.pop_front(), move);
        end
        prev = ptrs;
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        op(16'hE845, 0);
        repeat (2) @(negedge clk);
        report(indexedOffsetMode !== 1'b0, "mode while off");
        extendedSetEnableBit = 1'b1;
        repeat (2) @(negedge clk);
        report(indexedOffsetMode !== 1'b1, "mode while on");
        op(16'hE83F, 1);
        op(16'hE97F, 1);
        for (int i = 0; i < 30; i++) begin
            if (i % 5 == 4) op({8'hEA, 8'($random(seed))}, 1);
            else op({7'h74, 1'(i), 2'(i % 3), 6'($random(seed)) | 6'h01}, 1);
        end
        op(16'hE8C5, 1);
        op(16'hE801, 0);
        op(16'hE9C7, 1);
        @(posedge clk);
        @(posedge clk);
        op(WORD_CALL_W, 1);
        @(posedge clk);
        mv(16'hEB05, 16'hF123);
        mv(16'hEB85, 16'hF012);
        mv(16'hEB11, 16'h1234);
        repeat (4) @(negedge clk);
        report(notes.size() != 0 || moves.size() != 0, "results missing");
        summarize();
    end
    initial begin
        #(2000 * 25);
        report(1'b1, "watchdog expired");
        summarize();
    end
endmodule
bind eid_extended_decode eid_sva chk (
    .clk(clk), .rst_b(rst_b), .extendedSetEnableBit(extendedSetEnableBit),
    .instrValid(instrValid), .instrWord(instrWord), .stackTop(stackTop),
    .pcPlusTwo(pcPlusTwo), .workingRegister(workingRegister), .pcLatchHigh(pcLatchHigh),
    .pcLatchUpper(pcLatchUpper), .ptrs(ptrs), .memWrite(memWrite), .move(move),
    .busy(busy), .pcLoad(pcLoad), .pcValue(pcValue), .stackPush(stackPush),
    .stackPushValue(stackPushValue), .stackPop(stackPop), .extDecoded(extDecoded),
    .indexedOffsetMode(indexedOffsetMode), .statusWriteBlock(statusWriteBlock)
);
